// File: logic/wdtr_pkg.sv
// Purpose: Shared constants and types for the watchdog timer register block.
// Assumes: 10 MHz register clock; byte-wide register port at the printed byte addresses.
// Notes: One clock; the counter and its tick divider run only while the synchronised enable is high.
// Behaviour
// - Tick unit select 0 counts in 1 ms steps, 1 counts in 1 us steps.
// - Microsecond ticks come from the fast oscillator rate, milliseconds from the keep-alive rate.
// - Simulation speed-up bit forces a 1 MHz counting clock.
// - Underflow reset flag is set when the last reset came from counter underflow.
// - Writing one clears the underflow reset flag; writing zero leaves it.
// - After reset the flag reads one only if a watchdog reset occurred.
// - Enable bit set starts the watchdog; cleared stops it.
// - Counting starts only after a few synchronisation cycles following enable.
// - While enabled and no watchdog event is pending, any service register write reloads the counter and counting resumes.
// - Service writes while disabled are ignored and leave the counter alone.
// - Service register reads always return zero.
// - A service reload takes effect only after a few synchronisation cycles.
// - Count register is read-only 32 bits, a snapshot of the counter.
// - Reading the low count byte latches the whole counter for the upper bytes.
// - Underflow raises a watchdog system reset and sets the flag.
// - While a watchdog event is pending, register writes are blocked until the flag clears.
// - Clearing enable gates the tick clock and stops decrementing.
`default_nettype none

package wdtr_pkg;
    localparam int unsigned SYS_CLK_HZ    = 10_000_000;
    localparam int unsigned SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
    localparam int unsigned TICK_MS_NS    = 1_000_000;
    localparam int unsigned TICK_US_NS    = 1_000;
    localparam int unsigned SIM_CLK_HZ    = 1_000_000;
    localparam int unsigned SIM_PERIOD_NS = 1_000_000_000 / SIM_CLK_HZ;
    localparam int unsigned MS_CYCLES     = (TICK_MS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned US_CYCLES     = (TICK_US_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned SIM_CYCLES    = (SIM_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    localparam logic [15:0] ADDR_CTL_LO   = 16'h3000;
    localparam logic [15:0] ADDR_CTL_HI   = 16'h3001;
    localparam logic [15:0] ADDR_SERVICE  = 16'h3002;
    localparam logic [15:0] ADDR_COUNT_B0 = 16'h3004;
    localparam logic [15:0] ADDR_COUNT_B1 = 16'h3005;
    localparam logic [15:0] ADDR_COUNT_B2 = 16'h3006;
    localparam logic [15:0] ADDR_COUNT_B3 = 16'h3007;

    localparam int unsigned BIT_ENABLE    = 0;
    localparam int unsigned BIT_FLAG      = 1;
    localparam int unsigned BIT_SIM       = 2;
    localparam int unsigned BIT_UNITS     = 3;

    localparam logic [31:0] COUNT_RESET   = 32'hffffffff;
    localparam logic [7:0]  SERVICE_READ  = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ = 8'h00;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam int unsigned INIT_CYCLES   = 4;

    typedef struct packed {
        logic tick_unit_select;
        logic sim_speedup;
        logic underflow_reset_flag;
        logic watchdog_enable_bit;
    } wdtr_ctl_t;

    localparam wdtr_ctl_t CTL_RESET = '{tick_unit_select: 1'b0, sim_speedup: 1'b0,
                                        underflow_reset_flag: 1'b0, watchdog_enable_bit: 1'b0};
endpackage : wdtr_pkg

`default_nettype wire

// File: logic/wdtr_tick_div.sv
// Purpose: Divides the register clock into one-cycle tick enables for the watchdog counter.
// Assumes: Run low holds the divider cleared, which is how the tick clock is gated.
// Notes: Speed-up overrides the unit select.
`default_nettype none

module wdtr_tick_div #(
    parameter int unsigned MS_DIV  = wdtr_pkg::MS_CYCLES,
    parameter int unsigned US_DIV  = wdtr_pkg::US_CYCLES,
    parameter int unsigned SIM_DIV = wdtr_pkg::SIM_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic run_in,
    input  wire logic fast_in,
    input  wire logic sim_in,
    output var  logic tick_out
);
    localparam int unsigned W = $clog2(MS_DIV + US_DIV + SIM_DIV + 1);

    // A zero divider would wrap the limit to all ones and stretch the tick period, so it is refused up front.
    if (MS_DIV < 1 || US_DIV < 1 || SIM_DIV < 1) begin : g_bad_div
        $error("Tick dividers must be at least one cycle.");
    end

    logic [W-1:0] cnt_r;
    logic [W-1:0] limit;

    always_comb begin
        if (sim_in) begin
            limit = W'(SIM_DIV - 1);
        end else if (fast_in) begin
            limit = W'(US_DIV - 1);
        end else begin
            limit = W'(MS_DIV - 1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r    <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + W'(1);
            tick_out <= 1'b0;
        end
    end
endmodule // wdtr_tick_div

`default_nettype wire

// File: logic/wdtr_top.sv
// Purpose: Watchdog control, service and count-snapshot registers with the down counter.
// Assumes: Byte register port, one access per strobe; reload value comes from the load register outside.
// Notes: The generated system reset must not reset this block, so the flag survives it.
`default_nettype none

module wdtr_top #(
    parameter int unsigned MS_DIV = wdtr_pkg::MS_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reload_value_in,
    input  wire logic        wdt_cause_in,
    output var  logic [7:0]  reg_rdata_out,
    output var  logic        reg_rvalid_out,
    output var  logic        watchdog_reset_event_out,
    output var  logic        system_reset_req_out,
    output var  logic        fast_osc_req_out,
    output var  logic        write_blocked_out
);
    logic                   rst_s1_r;
    logic                   rst_s2_r;
    logic                   cause_s1_r;
    logic                   cause_s2_r;
    logic [2:0]             init_cnt_r;
    wdtr_pkg::wdtr_ctl_t    ctl_r;
    logic [wdtr_pkg::SYNC_STAGES-1:0] en_pipe_r;
    logic [wdtr_pkg::SYNC_STAGES-1:0] kick_pipe_r;
    logic                   en_live_r;
    logic [31:0]            count_r;
    logic [31:0]            snap_r;
    logic                   tick;
    logic                   underflow;
    logic                   wr_ctl_lo;
    logic                   wr_service;
    logic                   flag_clear;
    logic                   en_sync;
    logic                   kick_sync;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            cause_s1_r <= 1'b0;
            cause_s2_r <= 1'b0;
        end else begin
            cause_s1_r <= wdt_cause_in;
            cause_s2_r <= cause_s1_r;
        end
    end

    // The reset cause is only honoured for a short window after release; later wiggles are ignored.
    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            init_cnt_r <= 3'(wdtr_pkg::INIT_CYCLES);
        end else if (init_cnt_r != 3'h0) begin
            init_cnt_r <= init_cnt_r - 3'h1;
        end
    end

    // Writes are blocked while the flag is set; a control write with the flag bit at one still clears the flag, but its other bits are ignored.
    assign flag_clear = reg_wr_in && (reg_addr_in == wdtr_pkg::ADDR_CTL_LO)
                        && reg_wdata_in[wdtr_pkg::BIT_FLAG];
    assign wr_ctl_lo  = reg_wr_in && !ctl_r.underflow_reset_flag
                        && (reg_addr_in == wdtr_pkg::ADDR_CTL_LO);
    assign wr_service = reg_wr_in && !ctl_r.underflow_reset_flag
                        && (reg_addr_in == wdtr_pkg::ADDR_SERVICE)
                        && ctl_r.watchdog_enable_bit;

    assign en_sync   = en_pipe_r[wdtr_pkg::SYNC_STAGES-1];
    assign kick_sync = kick_pipe_r[wdtr_pkg::SYNC_STAGES-1];
    assign underflow = en_live_r && tick && (count_r == 32'h00000000);

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            ctl_r <= wdtr_pkg::CTL_RESET;
        end else begin
            if (wr_ctl_lo) begin
                ctl_r.watchdog_enable_bit <= reg_wdata_in[wdtr_pkg::BIT_ENABLE];
                ctl_r.sim_speedup         <= reg_wdata_in[wdtr_pkg::BIT_SIM];
                ctl_r.tick_unit_select    <= reg_wdata_in[wdtr_pkg::BIT_UNITS];
            end
            if (underflow || (cause_s2_r && init_cnt_r != 3'h0)) begin
                ctl_r.underflow_reset_flag <= 1'b1;
            end else if (flag_clear) begin
                ctl_r.underflow_reset_flag <= 1'b0;
            end
        end
    end

    // The enable and the service request cross a synchroniser-length delay so that the
    // latency software sees matches the oscillator-domain part.
    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            en_pipe_r   <= '0;
            kick_pipe_r <= '0;
            en_live_r   <= 1'b0;
        end else begin
            en_pipe_r   <= {en_pipe_r[wdtr_pkg::SYNC_STAGES-2:0], ctl_r.watchdog_enable_bit};
            kick_pipe_r <= {kick_pipe_r[wdtr_pkg::SYNC_STAGES-2:0], wr_service};
            en_live_r   <= en_sync;
        end
    end

    wdtr_tick_div #(
        .MS_DIV  (MS_DIV),
        .US_DIV  (wdtr_pkg::US_CYCLES),
        .SIM_DIV (wdtr_pkg::SIM_CYCLES)
    ) u_div (
        .clk_in   (sys_clk_in),
        .rst_b_in (rst_s2_r),
        .run_in   (en_live_r),
        .fast_in  (ctl_r.tick_unit_select),
        .sim_in   (ctl_r.sim_speedup),
        .tick_out (tick)
    );

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            count_r <= wdtr_pkg::COUNT_RESET;
        end else if (en_sync && !en_live_r) begin
            count_r <= reload_value_in;
        end else if (en_live_r && kick_sync && en_sync) begin
            count_r <= reload_value_in;
        end else if (underflow) begin
            count_r <= reload_value_in;
        end else if (en_live_r && tick) begin
            count_r <= count_r - 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            system_reset_req_out <= 1'b0;
        end else begin
            system_reset_req_out <= underflow;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            snap_r <= wdtr_pkg::COUNT_RESET;
        end else if (reg_rd_in && reg_addr_in == wdtr_pkg::ADDR_COUNT_B0) begin
            snap_r <= count_r;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    wdtr_pkg::ADDR_CTL_LO:   reg_rdata_out <= {4'h0, ctl_r};
                    wdtr_pkg::ADDR_CTL_HI:   reg_rdata_out <= 8'h00;
                    wdtr_pkg::ADDR_SERVICE:  reg_rdata_out <= wdtr_pkg::SERVICE_READ;
                    wdtr_pkg::ADDR_COUNT_B0: reg_rdata_out <= count_r[7:0];
                    wdtr_pkg::ADDR_COUNT_B1: reg_rdata_out <= snap_r[15:8];
                    wdtr_pkg::ADDR_COUNT_B2: reg_rdata_out <= snap_r[23:16];
                    wdtr_pkg::ADDR_COUNT_B3: reg_rdata_out <= snap_r[31:24];
                    default:                 reg_rdata_out <= wdtr_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            watchdog_reset_event_out <= 1'b0;
            write_blocked_out        <= 1'b0;
            fast_osc_req_out         <= 1'b0;
        end else begin
            watchdog_reset_event_out <= ctl_r.underflow_reset_flag;
            write_blocked_out        <= ctl_r.underflow_reset_flag;
            fast_osc_req_out         <= ctl_r.watchdog_enable_bit && ctl_r.tick_unit_select;
        end
    end
endmodule // wdtr_top

`default_nettype wire

// File: verification/test_wdtr_top.sv
// Purpose: Self-checking bench for the watchdog register block.
// Assumes: Millisecond divider shortened to 20 cycles.
// Notes: Reload 3 keeps each underflow run under a hundred cycles.
`default_nettype none
module test_wdtr_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned MSD = 20;
    logic sys_clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, wdt_cause_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic [31:0] reload_value_in = 32'h00000003;
    logic [7:0]  reg_rdata_out;
    logic reg_rvalid_out, watchdog_reset_event_out, system_reset_req_out, fast_osc_req_out, write_blocked_out;
    int errors = 0;
    int total_checks = 0;
    always #50 sys_clk_in = ~sys_clk_in;
    wdtr_top #(.MS_DIV(MSD)) wdtr_top_i (.sys_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reload_value_in, .wdt_cause_in, .reg_rdata_out, .reg_rvalid_out, .watchdog_reset_event_out,
        .system_reset_req_out, .fast_osc_req_out, .write_blocked_out);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(32'(reg_rvalid_out), 32'h1);
        d = reg_rdata_out;
    endtask
    // The gap after the low byte shows that the upper bytes come from the latched copy.
    task automatic rd_cnt(output logic [31:0] v);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            rd(16'h3004 + 16'(i), b);
            v[8*i +: 8] = b;
            if (i == 0) repeat (40) @(posedge sys_clk_in);
        end
    endtask
    task automatic t_reset(input logic cause);
        logic [7:0] b;
        logic [31:0] v;
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        wdt_cause_in <= cause;
        repeat (10) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        rd(16'h3000, b);
        chk(32'(b), 32'({cause, 1'b0}));
        rd(16'h3002, b);
        chk(32'(b), 32'h0);
        rd(16'h3010, b);
        chk(32'(b), 32'h0);
        rd_cnt(v);
        chk(v, 32'hffffffff);
        $display("reset test done");
    endtask
    task automatic t_mode(input logic [7:0] m, input int d);
        logic [7:0] b;
        int n;
        wr(16'h3000, 8'h00);
        reload_value_in <= 32'h3;
        wr(16'h3000, m);
        n = 0;
        while (system_reset_req_out !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_in);
            #1 n++;
        end
        chk(32'(n >= 4*d+3 && n <= 4*d+9), 32'h1);
        chk(32'(fast_osc_req_out), 32'(m[3]));
        rd(16'h3000, b);
        chk(32'(b), 32'(m | 8'h02));
        chk(32'({watchdog_reset_event_out, write_blocked_out}), 32'h3);
        wr(16'h3000, 8'h00);
        rd(16'h3000, b);
        chk(32'(b), 32'(m | 8'h02));
        wr(16'h3000, 8'h02);
        rd(16'h3000, b);
        chk(32'(b), 32'(m));
        chk(32'({watchdog_reset_event_out, write_blocked_out}), 32'h0);
        wr(16'h3000, 8'h00);
        $display("mode test done");
    endtask
    task automatic t_count();
        logic [31:0] a;
        logic [31:0] b;
        reload_value_in <= 32'h00012345;
        wr(16'h3000, 8'h09);
        repeat (100) @(posedge sys_clk_in);
        rd_cnt(a);
        chk(32'(a >= 32'h12335 && a <= 32'h1233d), 32'h1);
        wr(16'h3002, 8'h5a);
        repeat (3) @(posedge sys_clk_in);
        rd_cnt(b);
        chk(32'(b >= 32'h12344 && b <= 32'h12345), 32'h1);
        wr(16'h3000, 8'h00);
        repeat (5) @(posedge sys_clk_in);
        rd_cnt(a);
        wr(16'h3002, 8'h01);
        repeat (50) @(posedge sys_clk_in);
        rd_cnt(b);
        chk(b, a);
        $display("count test done");
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        print_verdict();
    end
    initial begin
        t_reset(1'b0);
        t_mode(8'h09, 10);
        t_mode(8'h01, MSD);
        t_mode(8'h0d, 10);
        t_count();
        t_reset(1'b1);
        print_verdict();
    end
endmodule // test_wdtr_top
bind wdtr_top wdtr_top_sva #(.MS_DIV(MS_DIV)) wdtr_top_sva_i (.sys_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reload_value_in, .wdt_cause_in, .reg_rdata_out, .reg_rvalid_out,
    .watchdog_reset_event_out, .system_reset_req_out, .fast_osc_req_out, .write_blocked_out);
`default_nettype wire

// File: verification/wdtr_top_sva.sv
// Purpose: Port checker for the watchdog register block.
// Assumes: One clock; reads and writes never overlap.
// Notes: Flag copies lag the flag, so their windows allow one cycle.
`default_nettype none
module wdtr_top_sva #(
    parameter int unsigned MS_DIV = 20
) (
    input wire logic        sys_clk_in,
    input wire logic        rst_b_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reload_value_in,
    input wire logic        wdt_cause_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_rvalid_out,
    input wire logic        watchdog_reset_event_out,
    input wire logic        system_reset_req_out,
    input wire logic        fast_osc_req_out,
    input wire logic        write_blocked_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire ctl_wr = reg_wr_in && reg_addr_in == 16'h3000;
    sequence s_pulse; system_reset_req_out ##1 !system_reset_req_out; endsequence
    property p_rd_ans; reg_rd_in |=> reg_rvalid_out; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_ans; !reg_rd_in |=> !reg_rvalid_out; endproperty
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    property p_svc_zero; reg_rd_in && reg_addr_in == 16'h3002 |=> reg_rdata_out == 8'h00; endproperty
    a_svc_zero: assert property (p_svc_zero) else $error("service read not zero");
    property p_rst_pulse; system_reset_req_out |-> s_pulse; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
    property p_rst_flag; system_reset_req_out |-> ##[0:1] write_blocked_out; endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("underflow left writes open");
    property p_evt; $rose(write_blocked_out) |-> ##[0:1] watchdog_reset_event_out; endproperty
    a_evt: assert property (p_evt) else $error("event not shown");
    property p_osc; ctl_wr && !write_blocked_out && reg_wdata_in[0] && reg_wdata_in[3] |-> ##[1:3] fast_osc_req_out;
    endproperty
    a_osc: assert property (p_osc) else $error("fast oscillator not requested");
    property p_clr; ctl_wr && write_blocked_out && reg_wdata_in[1] |-> ##[1:3] !write_blocked_out; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_keep; ctl_wr && write_blocked_out && !reg_wdata_in[1] |=> write_blocked_out; endproperty
    a_keep: assert property (p_keep) else $error("flag lost on zero write");
    property p_block;
        ctl_wr && write_blocked_out && !fast_osc_req_out && !reg_wdata_in[1] |=> !fast_osc_req_out [*3];
    endproperty
    a_block: assert property (p_block) else $error("blocked write took effect");
endmodule // wdtr_top_sva
`default_nettype wire
